// ==== verilog/prs_defs.svh ====
// timing figures, counts, bus address and codes of the pressure readout
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH
`define PRS_CLK_MHZ 100
`define PRS_T_START_US 10000
`define PRS_T_WIN_LOCK_US 1500
`define PRS_T_WIN_EXTRA_US 4500
`define PRS_T_MEAS_US 1000
`define PRS_T_PD_BASE_US 1000
`define PRS_SLOW_CORE_FACTOR 4
`define PRS_SPECIAL_EVERY 3'h3
`define PRS_I2C_ADDR 7'h28
`define PRS_ST_VALID 2'h0
`define PRS_ST_STALE 2'h2
`define PRS_FILL_BYTE 8'hFF
`endif

// ==== verilog/prs_pkg.sv ====
// state types of the pressure readout
package prs_pkg;
  typedef enum logic [1:0] {PRS_SQ_WINDOW, PRS_SQ_MEASURE, PRS_SQ_POWERDOWN, PRS_SQ_SLEEP} prs_seq_t;
  typedef enum logic [2:0] {PRS_I2_IDLE, PRS_I2_ADDR, PRS_I2_ACK, PRS_I2_TX, PRS_I2_HACK, PRS_I2_IGNORE} prs_i2c_t;
endpackage : prs_pkg

// ==== verilog/prs_spi_link.sv ====
// serial-clock side of the spi fetch: bit shifting and byte events
`timescale 1ns/1ps
`default_nettype none
module prs_spi_link (
  // link clock and frame select
  input wire logic sclk_in,
  input wire logic ss_n_in,
  input wire logic rst_in,
  // frozen output word from the core
  input wire logic [31:0] word_in,
  // serial data out
  output logic miso_out,
  output logic miso_oe_out,
  // toggles once per completed byte
  output logic byte_tgl_out
);
  logic [4:0] bit_idx; // bit being presented, cleared while deselected
  logic [2:0] rise_cnt; // rising edges within the current byte

  // data advances on the falling edge so the host samples a settled bit on the rise
  always_ff @(negedge sclk_in or posedge ss_n_in) begin
    if (ss_n_in) begin
      bit_idx <= 5'h00;
    end else begin
      bit_idx <= bit_idx + 5'h01;
    end
  end

  // count rising edges to mark byte completion
  always_ff @(posedge sclk_in or posedge ss_n_in) begin
    if (ss_n_in) begin
      rise_cnt <= 3'h0;
    end else begin
      rise_cnt <= rise_cnt + 3'h1;
    end
  end

  // byte event as a toggle, so the core can catch it across domains
  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      byte_tgl_out <= 1'b0;
    end else if (!ss_n_in && rise_cnt == 3'h7) begin
      byte_tgl_out <= ~byte_tgl_out;
    end
  end

  // msb first; the first bit stands from select so the first rise finds it
  assign miso_out = word_in[5'h1F - bit_idx];
  assign miso_oe_out = ~ss_n_in;
endmodule : prs_spi_link
`default_nettype wire

// ==== verilog/prs_readout.sv ====
// pressure readout core: power-up sequencing, measurement modes, i2c slave, spi fetch
`timescale 1ns/1ps
`default_nettype none
`include "prs_defs.svh"
module prs_readout #(
  parameter int START_CYC = `PRS_T_START_US * `PRS_CLK_MHZ,
  parameter int WIN_LOCK_CYC = `PRS_T_WIN_LOCK_US * `PRS_CLK_MHZ,
  parameter int WIN_EXTRA_CYC = `PRS_T_WIN_EXTRA_US * `PRS_CLK_MHZ,
  parameter int MEAS_CYC = `PRS_T_MEAS_US * `PRS_CLK_MHZ,
  parameter int PD_BASE_CYC = `PRS_T_PD_BASE_US * `PRS_CLK_MHZ
) (
  // core clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // factory straps, caught once after reset
  input wire logic i2c_sel_in,
  input wire logic sleep_mode_in,
  input wire logic [1:0] rate_in,
  input wire logic slow_core_in,
  input wire logic unlocked_in,
  // converter results from the front end, core domain
  input wire logic [13:0] bridge_adc_in,
  input wire logic [10:0] temp_adc_in,
  input wire logic [13:0] null_adc_in,
  // i2c pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // spi pins, sclk is the link clock
  input wire logic sclk_in,
  input wire logic ss_n_in,
  output logic miso_out,
  output logic miso_oe_out,
  // ready pin and status
  output logic int_out,
  output logic busy_out,
  output logic asleep_out,
  output logic fresh_out
);
  // caught straps
  logic cfg_taken; // straps captured
  logic cfg_i2c; // 1 selects i2c, 0 spi
  logic cfg_sleep; // 1 sleep mode, 0 update mode
  logic [1:0] cfg_rate; // update rate setting
  logic cfg_slow; // 1 MHz core clock
  logic cfg_unlocked; // configuration memory open
  // sequencer
  prs_pkg::prs_seq_t seq; // measurement sequencer state
  logic [31:0] seq_cnt; // cycles spent in window or measure, cycles left in power-down
  logic [31:0] start_cnt; // startup time counter
  logic cmd_ok; // startup time over, commands heard
  logic [2:0] meas_num; // bridge readings since last special one
  logic [13:0] null_val; // offset nulling value
  logic [10:0] temp_val; // last temperature
  logic [13:0] bridge_val; // last corrected bridge
  logic [1:0] status; // fresh or stale
  logic [31:0] out_word; // output register
  logic mr_pend; // measurement request pending
  logic new_result; // one-cycle strobe on result write
  logic read_done; // one-cycle strobe on finished fetch
  logic mr_strobe; // one-cycle strobe on request
  // pin synchronisers
  logic [1:0] scl_sy; // scl synchroniser
  logic [1:0] sda_sy; // sda synchroniser
  logic [1:0] ss_sy; // select synchroniser
  logic [1:0] tgl_sy; // byte toggle synchroniser
  logic scl_q; // previous synced scl
  logic sda_q; // previous synced sda
  logic ss_q; // previous synced select
  logic tgl_q; // previous synced toggle
  logic byte_tgl; // byte toggle from the link side
  logic [2:0] spi_bytes; // bytes clocked in this frame
  // i2c engine
  prs_pkg::prs_i2c_t i2s; // i2c slave state
  logic [3:0] i2_bit; // bit counter
  logic [7:0] i2_sh; // address shift register
  logic [2:0] i2_byte; // bytes sent in this read
  logic i2_rd; // read direction of this transfer
  logic fail_next; // next start is to be ignored
  logic clk_seen; // a scl rise since the last start
  logic start_ev; // start condition
  logic stop_ev; // stop condition
  logic scl_rise; // scl rising
  logic scl_fall; // scl falling
  logic [13:0] null_now; // offset applied to the present bridge reading
  localparam logic [7:0] FILL_BYTE = `PRS_FILL_BYTE; // bits sent past the fourth byte

  // scl, sda, select and the byte toggle cross two flip-flops; 100 MHz easily covers a 400 kHz bus
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      ss_sy <= 2'h3;
      tgl_sy <= 2'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ss_q <= 1'b1;
      tgl_q <= 1'b0;
    end else begin
      scl_sy <= {scl_sy[0], scl_in};
      sda_sy <= {sda_sy[0], sda_in};
      ss_sy <= {ss_sy[0], ss_n_in};
      tgl_sy <= {tgl_sy[0], byte_tgl};
      scl_q <= scl_sy[1];
      sda_q <= sda_sy[1];
      ss_q <= ss_sy[1];
      tgl_q <= tgl_sy[1];
    end
  end

  assign scl_rise = scl_sy[1] && !scl_q;
  assign scl_fall = !scl_sy[1] && scl_q;
  assign start_ev = cfg_i2c && scl_sy[1] && scl_q && !sda_sy[1] && sda_q;
  assign stop_ev = cfg_i2c && scl_sy[1] && scl_q && sda_sy[1] && !sda_q;

  // a special reading corrects with the offset it takes itself, else the first result would be uncorrected
  assign null_now = (meas_num == 3'h0) ? null_adc_in : null_val;

  // straps are sampled by a clock after release, never by the reset itself
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_taken <= 1'b0;
      cfg_i2c <= 1'b0;
      cfg_sleep <= 1'b0;
      cfg_rate <= 2'h0;
      cfg_slow <= 1'b0;
      cfg_unlocked <= 1'b0;
    end else if (!cfg_taken) begin
      cfg_taken <= 1'b1;
      cfg_i2c <= i2c_sel_in;
      cfg_sleep <= sleep_mode_in;
      cfg_rate <= rate_in;
      cfg_slow <= slow_core_in;
      cfg_unlocked <= unlocked_in;
    end
  end

  // commands are only heard once the startup time has passed
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_cnt <= 32'h0000_0000;
      cmd_ok <= 1'b0;
    end else if (!cmd_ok) begin
      start_cnt <= start_cnt + 32'h0000_0001;
      cmd_ok <= (start_cnt >= 32'(START_CYC - 1));
    end
  end

  // slow core stretches the measure and power-down intervals
  function automatic logic [31:0] prs_scale(input logic [31:0] cyc, input logic slow);
    prs_scale = slow ? cyc * 32'(`PRS_SLOW_CORE_FACTOR) : cyc;
  endfunction : prs_scale

  // measurement sequencer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      seq <= prs_pkg::PRS_SQ_WINDOW;
      seq_cnt <= 32'h0000_0000;
      meas_num <= 3'h0;
      new_result <= 1'b0;
    end else begin
      new_result <= 1'b0;
      unique case (seq)
        prs_pkg::PRS_SQ_WINDOW: begin
          // power-on command window, longer when the memory is open
          if (cfg_taken && seq_cnt >= (cfg_unlocked ? 32'(WIN_LOCK_CYC + WIN_EXTRA_CYC)
                                                    : 32'(WIN_LOCK_CYC))) begin
            seq <= prs_pkg::PRS_SQ_MEASURE;
            seq_cnt <= 32'h0000_0000;
          end else begin
            seq_cnt <= seq_cnt + 32'h0000_0001;
          end
        end
        prs_pkg::PRS_SQ_MEASURE: begin
          // conversion and correction; the result waits while a spi frame reads the register
          if (seq_cnt < prs_scale(32'(MEAS_CYC), cfg_slow)) begin
            seq_cnt <= seq_cnt + 32'h0000_0001;
          end else if (ss_sy[1]) begin
            new_result <= 1'b1;
            meas_num <= (meas_num == `PRS_SPECIAL_EVERY) ? 3'h0 : meas_num + 3'h1;
            if (cfg_sleep) begin
              seq <= prs_pkg::PRS_SQ_SLEEP;
              seq_cnt <= 32'h0000_0000;
            end else if (cfg_rate == 2'h0) begin
              seq_cnt <= 32'h0000_0000;
            end else begin
              seq <= prs_pkg::PRS_SQ_POWERDOWN;
              seq_cnt <= prs_scale(32'(PD_BASE_CYC) << cfg_rate, cfg_slow);
            end
          end
        end
        prs_pkg::PRS_SQ_POWERDOWN: begin
          // idle until the interval runs out, then wake for the next reading
          if (seq_cnt <= 32'h0000_0001) begin
            seq <= prs_pkg::PRS_SQ_MEASURE;
            seq_cnt <= 32'h0000_0000;
          end else begin
            seq_cnt <= seq_cnt - 32'h0000_0001;
          end
        end
        prs_pkg::PRS_SQ_SLEEP: begin
          if (mr_pend) begin
            seq <= prs_pkg::PRS_SQ_MEASURE;
            seq_cnt <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // one pending request; extra requests while measuring merge into it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mr_pend <= 1'b0;
    end else if (mr_strobe && cmd_ok && cfg_sleep) begin
      mr_pend <= 1'b1;
    end else if (seq == prs_pkg::PRS_SQ_SLEEP) begin
      mr_pend <= 1'b0;
    end
  end

  // results: special readings refresh temperature and offset nulling every few cycles
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      null_val <= 14'h0000;
      temp_val <= 11'h000;
      bridge_val <= 14'h0000;
    end else if (seq == prs_pkg::PRS_SQ_MEASURE && seq_cnt == 32'h0000_0000) begin
      if (meas_num == 3'h0) begin
        null_val <= null_adc_in;
        temp_val <= temp_adc_in;
      end
      bridge_val <= (bridge_adc_in > null_now) ? bridge_adc_in - null_now : 14'h0000;
    end
  end

  // status: a new result wins over a read finishing in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status <= `PRS_ST_STALE;
    end else if (new_result) begin
      status <= `PRS_ST_VALID;
    end else if (read_done) begin
      status <= `PRS_ST_STALE;
    end
  end

  // output register: status, bridge, temperature, five filler bits
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_word <= 32'h0000_0000;
    end else if (ss_sy[1]) begin
      out_word <= {status, bridge_val, temp_val, 5'h00};
    end
  end

  // spi frame bookkeeping: no bytes means a request, any byte means a fetch
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      spi_bytes <= 3'h0;
    end else if (!cfg_i2c && !ss_sy[1] && tgl_sy[1] != tgl_q && spi_bytes != 3'h7) begin
      spi_bytes <= spi_bytes + 3'h1;
    end else if (ss_sy[1]) begin
      spi_bytes <= 3'h0;
    end
  end

  // request and fetch strobes from either link
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mr_strobe <= 1'b0;
      read_done <= 1'b0;
    end else begin
      mr_strobe <= 1'b0;
      read_done <= 1'b0;
      if (!cfg_i2c && ss_sy[1] && !ss_q) begin
        mr_strobe <= (spi_bytes == 3'h0);
        read_done <= (spi_bytes != 3'h0) && cmd_ok;
      end else if (stop_ev && i2_rd && i2_byte != 3'h0) begin
        read_done <= 1'b1;
      end else if (i2s == prs_pkg::PRS_I2_ACK && scl_fall && !i2_rd) begin
        mr_strobe <= 1'b1;
      end
    end
  end

  // i2c slave with its three departures from the standard protocol
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      i2s <= prs_pkg::PRS_I2_IDLE;
      i2_bit <= 4'h0;
      i2_sh <= 8'h00;
      i2_byte <= 3'h0;
      i2_rd <= 1'b0;
      fail_next <= 1'b0;
      clk_seen <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (start_ev) begin
      // host keeps sda low from start through a zero first bit
      i2_bit <= 4'h0;
      i2_byte <= 3'h0;
      i2_rd <= 1'b0;
      clk_seen <= 1'b0;
      sda_oe_out <= 1'b0;
      if (i2s != prs_pkg::PRS_I2_IDLE) begin
        i2s <= prs_pkg::PRS_I2_IGNORE;
      end else if (fail_next || !cmd_ok) begin
        i2s <= prs_pkg::PRS_I2_IGNORE;
        fail_next <= 1'b0;
      end else begin
        i2s <= prs_pkg::PRS_I2_ADDR;
      end
    end else if (stop_ev) begin
      fail_next <= fail_next || !clk_seen;
      i2s <= prs_pkg::PRS_I2_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      if (scl_rise) begin
        clk_seen <= 1'b1;
      end
      unique case (i2s)
        prs_pkg::PRS_I2_IDLE, prs_pkg::PRS_I2_IGNORE: begin
          sda_oe_out <= 1'b0; // ignored transfers stay off the bus
        end
        prs_pkg::PRS_I2_ADDR: begin
          if (scl_rise) begin
            i2_sh <= {i2_sh[6:0], sda_sy[1]};
            i2_bit <= i2_bit + 4'h1;
          end else if (scl_fall && i2_bit == 4'h8) begin
            if (i2_sh[7:1] == `PRS_I2C_ADDR) begin
              i2s <= prs_pkg::PRS_I2_ACK;
              i2_rd <= i2_sh[0];
              sda_oe_out <= 1'b1; // pull low to acknowledge
            end else begin
              i2s <= prs_pkg::PRS_I2_IGNORE;
            end
          end
        end
        prs_pkg::PRS_I2_ACK: begin
          if (scl_fall) begin
            i2_bit <= 4'h1;
            if (i2_rd) begin
              i2s <= prs_pkg::PRS_I2_TX;
              sda_oe_out <= ~out_word[31];
            end else begin
              i2s <= prs_pkg::PRS_I2_IGNORE; // request taken, rest of write discarded
              sda_oe_out <= 1'b0;
            end
          end
        end
        prs_pkg::PRS_I2_TX: begin
          if (scl_fall) begin
            if (i2_bit == 4'h8) begin
              i2s <= prs_pkg::PRS_I2_HACK;
              i2_byte <= i2_byte + 3'h1;
              sda_oe_out <= 1'b0;
            end else begin
              i2_bit <= i2_bit + 4'h1;
              sda_oe_out <= (i2_byte < 3'h4) ? ~out_word[5'(8'h1F - {i2_byte, i2_bit[2:0]})]
                                             : ~FILL_BYTE[3'h7 - i2_bit[2:0]];
            end
          end
        end
        prs_pkg::PRS_I2_HACK: begin
          // a host nack ends the read; an ack asks for the next byte
          if (scl_rise && sda_sy[1]) begin
            i2s <= prs_pkg::PRS_I2_IGNORE;
          end else if (scl_fall) begin
            i2s <= prs_pkg::PRS_I2_TX;
            i2_bit <= 4'h1;
            sda_oe_out <= (i2_byte < 3'h4) ? ~out_word[5'(8'h1F - {i2_byte, 3'h0})] : 1'b0;
          end
        end
        default: begin
          i2s <= prs_pkg::PRS_I2_IDLE;
        end
      endcase
    end
  end

  // ready pin in i2c mode: rises on a new result, drops when a read begins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_out <= 1'b0;
    end else if (new_result && cfg_i2c) begin
      int_out <= 1'b1;
    end else if (i2s == prs_pkg::PRS_I2_ACK && i2_rd) begin
      int_out <= 1'b0;
    end
  end

  // status pins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      asleep_out <= 1'b0;
      fresh_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      busy_out <= (seq == prs_pkg::PRS_SQ_MEASURE);
      asleep_out <= (seq == prs_pkg::PRS_SQ_SLEEP) || (seq == prs_pkg::PRS_SQ_POWERDOWN);
      fresh_out <= (status == `PRS_ST_VALID);
      sda_out <= 1'b0; // open drain: only ever pulls low
    end
  end

  // spi link on its own clock
  prs_spi_link u_link (
    .sclk_in(sclk_in),
    .ss_n_in(ss_n_in),
    .rst_in(rst_in),
    .word_in(out_word),
    .miso_out(miso_out),
    .miso_oe_out(miso_oe_out),
    .byte_tgl_out(byte_tgl)
  );
endmodule : prs_readout
`default_nettype wire

// ==== test/prs_readout_asserts.sv ====
// port checker of the pressure readout, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module prs_readout_chk #(
  parameter int WIN_LOCK_CYC = 50,
  parameter int WIN_EXTRA_CYC = 100,
  parameter int MEAS_CYC = 30
) (
  // clock, reset and straps
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic i2c_sel_in,
  input wire logic sleep_mode_in,
  input wire logic [1:0] rate_in,
  input wire logic slow_core_in,
  input wire logic unlocked_in,
  // link and outputs
  input wire logic ss_n_in,
  input wire logic sda_out,
  input wire logic miso_oe_out,
  input wire logic int_out,
  input wire logic busy_out,
  input wire logic asleep_out,
  input wire logic fresh_out
);
  logic [15:0] up_cnt; // cycles since reset release, saturating
  logic [3:0] sel_age; // cycles since select was last low, saturating
  // uptime counter
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) up_cnt <= 16'h0000;
    else if (up_cnt != 16'hFFFF) up_cnt <= up_cnt + 16'h0001;
  end
  // select age, so a stale flag can be tied to a finished frame
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) sel_age <= 4'hF;
    else if (!ss_n_in) sel_age <= 4'h0;
    else if (sel_age != 4'hF) sel_age <= sel_age + 4'h1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_oe_select: assert property (miso_oe_out == !ss_n_in) else $error("miso enable not tied to select");
  chk_sda_low: assert property (sda_out == 1'b0) else $error("sda driven high");
  chk_lock_early: assert property (busy_out && !unlocked_in |-> up_cnt >= WIN_LOCK_CYC)
    else $error("measure inside locked window");
  chk_unlock_early: assert property (busy_out && unlocked_in |-> up_cnt >= WIN_LOCK_CYC + WIN_EXTRA_CYC)
    else $error("measure inside unlocked window");
  chk_first_result: assert property ((up_cnt == 16'(WIN_LOCK_CYC + MEAS_CYC + 6)) && !unlocked_in && !slow_core_in
    |-> fresh_out) else $error("first result late");
  chk_meas_span: assert property ($rose(busy_out) |-> busy_out[*8]) else $error("measure cut short");
  chk_fresh_after: assert property ($fell(busy_out) |-> ##[0:2] fresh_out) else $error("no result after measure");
  chk_power_down: assert property ($fell(busy_out) && !sleep_mode_in && rate_in != 2'h0 |-> !busy_out[*8])
    else $error("no power-down gap");
  chk_sleep_idle: assert property ((sleep_mode_in && !i2c_sel_in && asleep_out && ss_n_in && up_cnt > 16'h0200)[*8]
    |=> !busy_out) else $error("measure without request");
  chk_stale_read: assert property ($fell(fresh_out) && !i2c_sel_in |-> sel_age < 4'h8)
    else $error("stale without read");
  chk_int_mode: assert property (int_out |-> i2c_sel_in) else $error("ready pin outside i2c");
  chk_int_fresh: assert property ($rose(int_out) |-> ##1 fresh_out) else $error("ready pin without data");
  cov_fresh: cover property ($rose(fresh_out));
  cov_stale: cover property ($fell(fresh_out));
  cov_int: cover property ($rose(int_out));
endmodule : prs_readout_chk
bind prs_readout prs_readout_chk #(.WIN_LOCK_CYC(WIN_LOCK_CYC), .WIN_EXTRA_CYC(WIN_EXTRA_CYC), .MEAS_CYC(MEAS_CYC))
  u_chk (.clk_in(clk_in), .rst_in(rst_in), .i2c_sel_in(i2c_sel_in), .sleep_mode_in(sleep_mode_in),
  .rate_in(rate_in), .slow_core_in(slow_core_in), .unlocked_in(unlocked_in), .ss_n_in(ss_n_in),
  .sda_out(sda_out), .miso_oe_out(miso_oe_out), .int_out(int_out), .busy_out(busy_out),
  .asleep_out(asleep_out), .fresh_out(fresh_out));
`default_nettype wire

// ==== test/prs_spi_host.sv ====
// host master model on the spi link of the pressure readout
`timescale 1ns/1ps
`default_nettype none
module prs_spi_host (
  // link towards the readout
  output logic sclk_out,
  output logic ss_n_out,
  input wire logic miso_in
);
  localparam real HALF = 62.5; // half of the 125 ns link period
  event got; // a fetched word is ready in rx
  logic [31:0] rx; // received bits, first bit at the top
  // clock stands low outside frames
  initial begin
    sclk_out = 1'b0;
    ss_n_out = 1'b1;
  end
  // nb complete bytes; zero bytes makes a measurement request frame
  task automatic frame(input int nb);
    int i;
    rx = 32'h00000000;
    ss_n_out = 1'b0;
    #(2 * HALF); // lets the core freeze its word before the first rise
    for (i = 0; i < nb * 8; i++) begin
      sclk_out = 1'b1;
      if (i < 32) rx[31 - i] = miso_in;
      #(HALF);
      sclk_out = 1'b0;
      #(HALF);
    end
    ss_n_out = 1'b1;
    if (nb > 0) -> got;
    #(4 * HALF); // idle gap so the stale marking lands before the next step
  endtask : frame
endmodule : prs_spi_host
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench of the pressure readout, fetched over spi and i2c
`timescale 1ns/1ps
`default_nettype none
`include "prs_defs.svh"
module testbench;
  logic clk_in, rst_in, i2c_sel, sleep_mode, slow_core, unlocked, sclk, ss_n;
  logic scl, sda_h, sda_line, ak; // i2c clock, host side of sda, the pulled-up wire, address ack
  logic [7:0] rb; // byte read over i2c
  logic [31:0] ew; // word expected behind the i2c read
  logic [1:0] rate;
  logic [13:0] bridge, null_v, b_dut, n_dut; // driven values and those the core should hold
  logic [10:0] temp, t_dut;
  logic miso, miso_oe, sda, sda_oe, int_o, busy, asleep, fresh;
  logic [63:0] expq[$]; // mask and expected word of each pending fetch
  logic [63:0] e;
  int n_fail, n_compared, seed, cyc, k, gap;
  // open-drain sda: the pull-up wins unless host or core pulls low
  assign sda_line = sda_h & ~sda_oe;
  prs_readout #(.START_CYC(200), .WIN_LOCK_CYC(50), .WIN_EXTRA_CYC(100), .MEAS_CYC(30), .PD_BASE_CYC(20)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .i2c_sel_in(i2c_sel), .sleep_mode_in(sleep_mode), .rate_in(rate),
    .slow_core_in(slow_core), .unlocked_in(unlocked), .bridge_adc_in(bridge), .temp_adc_in(temp),
    .null_adc_in(null_v), .scl_in(scl), .sda_in(sda_line), .sda_out(sda), .sda_oe_out(sda_oe),
    .sclk_in(sclk), .ss_n_in(ss_n), .miso_out(miso), .miso_oe_out(miso_oe), .int_out(int_o),
    .busy_out(busy), .asleep_out(asleep), .fresh_out(fresh));
  prs_spi_host host (.sclk_out(sclk), .ss_n_out(ss_n), .miso_in(miso));
  // 100 MHz core clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // word as the core should present it, correction floored at zero
  function automatic logic [31:0] word(input logic [1:0] st);
    logic [13:0] b;
    b = (b_dut > n_dut) ? b_dut - n_dut : 14'h0000;
    return {st, b, t_dut, 5'h00};
  endfunction : word
  // note the expectation, masked to the bytes read, then clock the frame
  task automatic fetch(input int nb, input logic [1:0] st);
    logic [31:0] m;
    m = (nb == 2) ? 32'hFFFF0000 : (nb == 3) ? 32'hFFFFFF00 : 32'hFFFFFFE0;
    expq.push_back({m, word(st) & m});
    host.frame(nb);
    tick();
  endtask : fetch
  task automatic wait_busy(input logic v);
    for (k = 0; k < 3000 && busy !== v; k++) tick();
  endtask : wait_busy
  task automatic wait_meas();
    wait_busy(1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask : wait_meas
  task automatic wait_fresh();
    for (k = 0; k < 3000 && fresh !== 1'b1; k++) tick();
    check("fresh", 32'h1, {31'h0, fresh});
  endtask : wait_fresh
  // i2c host at 100 kHz, legal for either core clock: start, read address, one byte, nack, stop
  task automatic i2c_read(output logic ack, output logic [7:0] rd);
    int i;
    logic [7:0] a;
    a = {`PRS_I2C_ADDR, 1'b1};
    ack = 1'b1;
    rd = 8'h00;
    sda_h = 1'b0;
    repeat (500) tick();
    // sda stays low from the start through a zero first address bit
    scl = 1'b0;
    for (i = 0; i < 18; i++) begin
      sda_h = (i < 8) ? a[7 - i] : 1'b1;
      repeat (500) tick();
      scl = 1'b1;
      repeat (500) tick();
      if (i == 8) ack = sda_line;
      if (i > 8 && i < 17) rd = {rd[6:0], sda_line};
      scl = 1'b0;
    end
    sda_h = 1'b0;
    repeat (500) tick();
    scl = 1'b1;
    repeat (500) tick();
    sda_h = 1'b1;
    repeat (500) tick();
  endtask : i2c_read
  // straps change only under reset; commands wait out the startup time
  task automatic restart(input logic isel, input logic slp, input logic [1:0] rt, input logic slw, input logic unl);
    tick();
    rst_in = 1'b1;
    {i2c_sel, sleep_mode, rate, slow_core, unlocked} = {isel, slp, rt, slw, unl};
    bridge = 14'($random(seed));
    temp = 11'($random(seed));
    null_v = 14'($random(seed)) >> 2;
    {b_dut, t_dut, n_dut} = {bridge, temp, null_v};
    repeat (12) tick();
    rst_in = 1'b0;
    repeat (203) tick();
  endtask : restart
  // result monitor: each fetched word against the oldest note
  initial begin
    forever begin
      @(host.got);
      e = expq.pop_front();
      check("fetch", e[31:0], host.rx & e[63:32]);
    end
  end
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      $display("[ERR] run expected end seen timeout");
      test_done();
    end
  end
  initial begin
    seed = 39;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    rst_in = 1'b1;
    {i2c_sel, sleep_mode, rate, slow_core, unlocked} = 6'h00;
    {bridge, temp, null_v} = 39'h0000000000;
    {scl, sda_h} = 2'h3;
    // sleep mode: one result after power-up, then only on request
    restart(1'b0, 1'b1, 2'h0, 1'b0, 1'b0);
    wait_fresh();
    fetch(4, 2'h0);
    fetch(4, 2'h2);
    bridge = 14'($random(seed));
    repeat (300) tick();
    check("busy", 32'h0, {31'h0, busy});
    fetch(3, 2'h2);
    host.frame(0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    b_dut = bridge;
    wait_fresh();
    fetch(4, 2'h0);
    check("asleep", 32'h1, {31'h0, asleep});
    $display("test sleep done");
    // update mode, slower rate, unlocked window
    restart(1'b0, 1'b0, 2'h2, 1'b0, 1'b1);
    wait_fresh();
    fetch(2, 2'h0);
    bridge = 14'($random(seed));
    wait_meas();
    b_dut = bridge;
    wait_fresh();
    fetch(4, 2'h0);
    gap = 0;
    while (busy !== 1'b1 && gap < 3000) begin
      tick();
      gap++;
    end
    wait_busy(1'b0);
    for (gap = 0; busy !== 1'b1 && gap < 3000; gap++) tick();
    check("gap", 32'h1, {31'h0, (gap >= 78 && gap <= 82)});
    temp = 11'($random(seed));
    null_v = 14'($random(seed)) >> 2;
    repeat (5) wait_meas();
    {t_dut, n_dut} = {temp, null_v};
    wait_fresh();
    fetch(4, 2'h0);
    $display("test update done");
    // i2c strap, fastest rate, slow core: ready pin and continuous runs
    restart(1'b1, 1'b0, 2'h0, 1'b1, 1'b0);
    for (k = 0; k < 3000 && int_o !== 1'b1; k++) tick();
    check("int", 32'h1, {31'h0, int_o});
    check("asleep", 32'h0, {31'h0, asleep});
    ew = word(2'h0);
    i2c_read(ak, rb);
    check("i2c ack", 32'h0, {31'h0, ak});
    check("i2c byte", {24'h0, ew[31:24]}, {24'h0, rb});
    $display("test ready done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
